// ---- hdl/lcfs_defs.svh ----
// constants of the led channel fault supervisor: offsets, fields, timing
// assumes a 50 MHz core clock and at most 16 led channels
`ifndef LCFS_DEFS_SVH
`define LCFS_DEFS_SVH

`define LCFS_CLK_MHZ 50
`define LCFS_RETEST_NS 10000
`define LCFS_RETEST_CYC ((`LCFS_RETEST_NS * `LCFS_CLK_MHZ + 999) / 1000)

`define LCFS_OFS_FAULT_A 8'h38
`define LCFS_OFS_FAULT_B 8'h39
`define LCFS_OFS_LATREG_LO 8'h3a
`define LCFS_OFS_LATREG_HI 8'h3b
`define LCFS_OFS_GND_LO 8'h3c
`define LCFS_OFS_GND_HI 8'h3d

`define LCFS_FA_OCP 0
`define LCFS_FA_UV 1
`define LCFS_FA_TW 2
`define LCFS_FA_OVP 3
`define LCFS_FB_OPEN 0
`define LCFS_FB_GND 1

`define LCFS_RST_BYTE 8'h00

`endif

// ---- hdl/lcfs_pkg.sv ----
// types of the led channel fault supervisor
// assumes nothing beyond a systemverilog compiler
package lcfs_pkg;
    typedef enum logic [2:0] {
        LCFS_RUN = 3'b000,
        LCFS_OVP_HOLD = 3'b001,
        LCFS_RETEST = 3'b010,
        LCFS_SHUT = 3'b011,
        LCFS_OCP = 3'b100,
        LCFS_UV = 3'b101
    } lcfs_state_t;
endpackage

// ---- hdl/lcfs_supervisor.sv ----
// fault supervisor of a multi channel boost led driver
// assumes analog comparators on pins, synchronised here, and a host
// reading status through a byte read port behind the serial interface
`timescale 1ns/1ps
`include "lcfs_defs.svh"
module lcfs_supervisor #(
    parameter int NCH = 10,
    parameter int RETEST_CYC = `LCFS_RETEST_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [NCH-1:0] i_ch_enable,
    input wire logic [NCH-1:0] i_ch_in_reg,
    input wire logic [NCH-1:0] i_ch_gnd,
    input wire logic i_overvoltage_trip,
    input wire logic i_ov_below_94,
    input wire logic i_in_ocp,
    input wire logic i_out_uv,
    input wire logic i_temp_warn,
    input wire logic i_uv_auto_restart,
    input wire logic i_tw_auto_restart,
    input wire logic i_fault_clear,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_valid,
    output logic [NCH-1:0] o_boost_raise_req,
    output logic [NCH-1:0] o_ch_active,
    output logic o_gnd_test,
    output logic o_boost_en,
    output logic o_in_disc_on,
    output logic o_led_en,
    output logic o_led_derate,
    output logic o_fault_pin_out,
    output logic o_fault_pin_oe
);
    localparam int SYNW = 3 * NCH + 5;
    localparam logic [15:0] RETEST_LAST = 16'(RETEST_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SYNW-1:0] syn_in;
    logic [SYNW-1:0] syn_out;
    logic [NCH-1:0] in_reg_s;
    logic [NCH-1:0] gnd_s;
    logic [NCH-1:0] en_s;
    logic ovp_s;
    logic below_s;
    logic ocp_s;
    logic uv_s;
    logic tw_s;

    assign syn_in = {i_ch_enable, i_ch_in_reg, i_ch_gnd, i_overvoltage_trip,
                     i_ov_below_94, i_in_ocp, i_out_uv, i_temp_warn};

    lcfs_sync #(
        .W(SYNW)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(syn_in),
        .o_sync(syn_out)
    );

    assign {en_s, in_reg_s, gnd_s, ovp_s, below_s, ocp_s, uv_s, tw_s} =
        syn_out;

    ////////////////////////////////////////////////////////////////////////
    // supervisor state

    lcfs_pkg::lcfs_state_t state_reg;
    lcfs_pkg::lcfs_state_t state_next;
    logic [NCH-1:0] removed_reg;
    logic [NCH-1:0] removed_next;
    logic [NCH-1:0] cap_reg;
    logic [NCH-1:0] cap_next;
    logic [NCH-1:0] latreg_reg;
    logic [NCH-1:0] latreg_next;
    logic [NCH-1:0] gnd_reg;
    logic [NCH-1:0] gnd_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [3:0] fa_reg;
    logic [3:0] fa_next;
    logic [1:0] fb_reg;
    logic [1:0] fb_next;
    logic tw_reg;
    logic tw_next;
    logic [NCH-1:0] active;
    logic [NCH-1:0] unreg;
    logic [NCH-1:0] grounded;

    // removed channels no longer take part in the boost loop
    assign active = en_s & ~removed_reg;
    assign unreg = active & ~in_reg_s;
    assign grounded = cap_reg & gnd_s;

    // next state; overcurrent outranks everything except in the retest and shutdown states, where it is not checked
    always_comb
    begin
        state_next = state_reg;
        removed_next = removed_reg;
        cap_next = cap_reg;
        latreg_next = latreg_reg;
        gnd_next = gnd_reg;
        cnt_next = cnt_reg;
        fa_next = fa_reg;
        fb_next = fb_reg;
        tw_next = tw_reg;
        // host clear first, so a fresh event below wins over it
        if (i_fault_clear)
        begin
            fa_next = 4'h0;
            fb_next = 2'h0;
        end
        // warning releases on cooling if auto, else on host clear
        if (tw_s)
        begin
            tw_next = 1'b1;
            fa_next[`LCFS_FA_TW] = 1'b1;
        end
        else if (i_tw_auto_restart || i_fault_clear)
        begin
            tw_next = 1'b0;
        end
        case (state_reg)
            lcfs_pkg::LCFS_RUN:
            begin
                cnt_next = 16'h0000;
                if (ocp_s)
                begin
                    state_next = lcfs_pkg::LCFS_OCP;
                    fa_next[`LCFS_FA_OCP] = 1'b1;
                end
                else if (uv_s)
                begin
                    state_next = lcfs_pkg::LCFS_UV;
                    fa_next[`LCFS_FA_UV] = 1'b1;
                end
                else if (ovp_s)
                begin
                    fa_next[`LCFS_FA_OVP] = 1'b1;
                    if (unreg != '0)
                    begin
                        // startup failures follow this same path
                        state_next = lcfs_pkg::LCFS_RETEST;
                        cap_next = unreg;
                        latreg_next = latreg_reg | unreg;
                    end
                    else
                    begin
                        state_next = lcfs_pkg::LCFS_OVP_HOLD;
                    end
                end
            end
            lcfs_pkg::LCFS_OVP_HOLD:
            begin
                if (ocp_s)
                begin
                    state_next = lcfs_pkg::LCFS_OCP;
                    fa_next[`LCFS_FA_OCP] = 1'b1;
                end
                else if (below_s)
                begin
                    state_next = lcfs_pkg::LCFS_RUN;
                end
            end
            lcfs_pkg::LCFS_RETEST:
            begin
                if (cnt_reg != RETEST_LAST)
                begin
                    cnt_next = cnt_reg + 16'h0001;
                end
                else if (grounded != '0)
                begin
                    state_next = lcfs_pkg::LCFS_SHUT;
                    gnd_next = gnd_reg | grounded;
                    fb_next[`LCFS_FB_GND] = 1'b1;
                end
                else
                begin
                    removed_next = removed_reg | cap_reg;
                    fb_next[`LCFS_FB_OPEN] = 1'b1;
                    state_next = lcfs_pkg::LCFS_RUN;
                end
            end
            lcfs_pkg::LCFS_SHUT:
            begin
                // only a reset brings the boost back
                state_next = lcfs_pkg::LCFS_SHUT;
                fb_next[`LCFS_FB_GND] = 1'b1;
            end
            lcfs_pkg::LCFS_OCP:
            begin
                // the clear that releases the latch also empties the bit,
                // otherwise the host would need a second clear
                if (i_fault_clear && !ocp_s)
                begin
                    state_next = lcfs_pkg::LCFS_RUN;
                end
                else
                begin
                    fa_next[`LCFS_FA_OCP] = 1'b1;
                end
            end
            lcfs_pkg::LCFS_UV:
            begin
                if (ocp_s)
                begin
                    state_next = lcfs_pkg::LCFS_OCP;
                    fa_next[`LCFS_FA_OCP] = 1'b1;
                end
                else if (!uv_s && (i_uv_auto_restart || i_fault_clear))
                begin
                    state_next = lcfs_pkg::LCFS_RUN;
                end
            end
            default:
            begin
                state_next = lcfs_pkg::LCFS_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_reg <= lcfs_pkg::LCFS_RUN;
            removed_reg <= '0;
            cap_reg <= '0;
            latreg_reg <= '0;
            gnd_reg <= '0;
            cnt_reg <= 16'h0000;
            fa_reg <= 4'h0;
            fb_reg <= 2'h0;
            tw_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            removed_reg <= removed_next;
            cap_reg <= cap_next;
            latreg_reg <= latreg_next;
            gnd_reg <= gnd_next;
            cnt_reg <= cnt_next;
            fa_reg <= fa_next;
            fb_reg <= fb_next;
            tw_reg <= tw_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power stage controls and indicator

    logic running;
    logic flag;

    assign running = (state_reg == lcfs_pkg::LCFS_RUN);
    // an open or grounded string never reaches target, so it keeps asking
    assign o_boost_raise_req = running ? unreg : '0;
    assign o_ch_active = active;
    assign o_gnd_test = (state_reg == lcfs_pkg::LCFS_RETEST);
    // sinks stay on during the hold so the output can drain
    assign o_boost_en = running;
    assign o_in_disc_on = (state_reg != lcfs_pkg::LCFS_OCP) &&
                          (state_reg != lcfs_pkg::LCFS_SHUT);
    assign o_led_en = (state_reg == lcfs_pkg::LCFS_RUN) ||
                      (state_reg == lcfs_pkg::LCFS_OVP_HOLD) ||
                      (state_reg == lcfs_pkg::LCFS_RETEST);
    assign o_led_derate = tw_reg;
    // warning is left out of the indicator on purpose
    assign flag = !running;
    assign o_fault_pin_out = 1'b0;
    assign o_fault_pin_oe = flag;

    ////////////////////////////////////////////////////////////////////////
    // status read port

    logic [15:0] latreg_w;
    logic [15:0] gnd_w;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic valid_reg;
    logic valid_next;

    // pad the channel vectors into two bytes, channel 0 at bit 0
    assign latreg_w = 16'(latreg_reg);
    assign gnd_w = 16'(gnd_reg);

    // unmapped offsets read as zero
    always_comb
    begin
        rdata_next = rdata_reg;
        valid_next = i_reg_rd;
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                `LCFS_OFS_FAULT_A: rdata_next = {4'h0, fa_reg};
                `LCFS_OFS_FAULT_B: rdata_next = {6'h00, fb_reg};
                `LCFS_OFS_LATREG_LO: rdata_next = latreg_w[7:0];
                `LCFS_OFS_LATREG_HI: rdata_next = latreg_w[15:8];
                `LCFS_OFS_GND_LO: rdata_next = gnd_w[7:0];
                `LCFS_OFS_GND_HI: rdata_next = gnd_w[15:8];
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rdata_reg <= `LCFS_RST_BYTE;
            valid_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            valid_reg <= valid_next;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_reg_valid = valid_reg;
endmodule

// ---- hdl/lcfs_sync.sv ----
// two flip-flop synchroniser for a group of level inputs
// assumes levels that stay put for several clock cycles
`timescale 1ns/1ps
module lcfs_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            logic meta_reg;
            logic meta_next;
            logic out_reg;
            logic out_next;
            // the first stage feeds the second stage only
            always_comb
            begin
                meta_next = i_async[gi];
                out_next = meta_reg;
            end
            always_ff @(posedge i_clk)
            begin
                if (i_rst)
                begin
                    meta_reg <= 1'b0;
                    out_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= meta_next;
                    out_reg <= out_next;
                end
            end
            assign o_sync[gi] = out_reg;
        end
    endgenerate
endmodule

// ---- testbench/lcfs_plant.sv ----
// plant model: boost output level, led sinks and pin comparators
// assumes the supervisor's outputs, one step of output per clock
`timescale 1ns/1ps
module lcfs_plant (
    input wire logic i_clk,
    input wire logic i_boost_en,
    input wire logic [9:0] i_raise,
    input wire logic i_gnd_test,
    input wire logic [9:0] i_open,
    input wire logic [9:0] i_short,
    input wire logic i_surge,
    output logic [9:0] o_in_reg,
    output logic [9:0] o_gnd,
    output logic o_ovt,
    output logic o_below
);
    int vout = 0;
    // raise requests ramp the output; stopped boost lets sinks drain it
    always @(posedge i_clk)
    begin
        if (i_surge)
            vout <= 105;
        else if (!i_boost_en && vout > 0)
            vout <= vout - 1;
        else if (i_boost_en && |i_raise && vout < 110)
            vout <= vout + 1;
    end
    // a dead pin never regulates; ground comparator only live in retest
    always_comb
    begin
        o_in_reg = (vout >= 50) ? ~(i_open | i_short) : 10'h000;
        o_gnd = i_gnd_test ? i_short : 10'h000;
        o_ovt = vout >= 100;
        o_below = vout < 94;
    end
endmodule

// ---- testbench/lcfs_supervisor_chk.sv ----
// port checker of the led channel fault supervisor
// assumes binding into lcfs_supervisor, one clock, sync reset high
`timescale 1ns/1ps
module lcfs_supervisor_chk #(
    parameter int NCH = 10,
    parameter int RETEST_CYC = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [NCH-1:0] i_ch_in_reg,
    input wire logic i_overvoltage_trip,
    input wire logic i_in_ocp,
    input wire logic i_out_uv,
    input wire logic i_temp_warn,
    input wire logic i_reg_rd,
    input wire logic o_reg_valid,
    input wire logic [NCH-1:0] o_boost_raise_req,
    input wire logic [NCH-1:0] o_ch_active,
    input wire logic o_gnd_test,
    input wire logic o_boost_en,
    input wire logic o_in_disc_on,
    input wire logic o_led_en,
    input wire logic o_led_derate,
    input wire logic o_fault_pin_out,
    input wire logic o_fault_pin_oe
);
    int gcnt_reg;
    logic shut_reg;
    ////////////////////////////////////////////////////////////////////
    // retest length counter and a sticky mark once shutdown is entered
    always_ff @(posedge i_clk)
    begin
        gcnt_reg <= (i_rst || !o_gnd_test) ? 0 : gcnt_reg + 1;
        shut_reg <= !i_rst &&
            (shut_reg || ($fell(o_gnd_test) && !o_in_disc_on));
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // boost and leds stopped with the indicator pulled low
    sequence s_stop;
        !o_boost_en && !o_led_en && o_fault_pin_oe;
    endsequence
    ////////////////////////////////////////////////////////////////////
    chk_read_answer: assert property (o_reg_valid == $past(i_reg_rd))
        else $error("read answer timing");
    chk_raise_run: assert property (|o_boost_raise_req |-> o_boost_en
        && (o_boost_raise_req & ~o_ch_active) == '0) else $error("raise");
    chk_pin_state: assert property (!o_fault_pin_out
        && o_fault_pin_oe == !o_boost_en) else $error("indicator");
    chk_trip_retest: assert property ($rose(i_overvoltage_trip)
        && o_boost_en && !i_in_ocp && !i_out_uv
        && |(o_ch_active & ~i_ch_in_reg) |-> ##[1:3] o_gnd_test)
        else $error("no retest");
    chk_retest_len: assert property ($fell(o_gnd_test)
        |-> gcnt_reg == RETEST_CYC) else $error("retest length");
    chk_shut_stays: assert property (shut_reg |-> !o_boost_en
        && !o_in_disc_on && o_fault_pin_oe) else $error("shutdown left");
    chk_open_resume: assert property ($fell(o_gnd_test) && o_in_disc_on
        |-> o_boost_en && !o_fault_pin_oe) else $error("no resume");
    chk_ocp_off: assert property ($rose(i_in_ocp) && o_boost_en
        |-> ##3 s_stop ##0 !o_in_disc_on) else $error("ocp action");
    chk_uv_stop: assert property ($rose(i_out_uv) && o_boost_en
        && !i_in_ocp |-> ##3 s_stop ##0 o_in_disc_on) else $error("uv");
    chk_warn_derate: assert property ($rose(i_temp_warn) && o_boost_en
        |-> ##[2:4] (o_led_derate && o_boost_en && !o_fault_pin_oe))
        else $error("warning action");
endmodule
bind lcfs_supervisor lcfs_supervisor_chk #(.NCH(NCH),
    .RETEST_CYC(RETEST_CYC)) u_lcfs_supervisor_chk (.*);

// ---- testbench/tb_lcfs_supervisor.sv ----
// self-checking bench: status read through the byte port, plant on pins
// assumes the plant and the checker compiled before it
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    err_total++; $display("BAD %0t got %h want %h", $time, a, e); end end
`define WAITC(c) for (k = 0; k < 300 && !(c); k++) \
    begin @(posedge i_clk); #1; end \
    if (k == 300) begin err_total++; \
    $display("BAD %0t wait ran out", $time); end
module tb_lcfs_supervisor;
    int err_total = 0, samples_checked = 0, k;
    logic i_clk = 1'b0, i_rst = 1'b1, i_in_ocp = 1'b0, i_out_uv = 1'b0;
    logic i_temp_warn = 1'b0, i_fault_clear = 1'b0, i_reg_rd = 1'b0;
    logic surge = 1'b0, uv_auto = 1'b1, i_overvoltage_trip, i_ov_below_94;
    logic [7:0] i_reg_addr = 8'h00, o_reg_rdata;
    logic [9:0] open_ch = 10'h000, short_ch = 10'h000, i_ch_in_reg;
    logic [9:0] i_ch_gnd, o_boost_raise_req, o_ch_active;
    logic o_reg_valid, o_gnd_test, o_boost_en, o_in_disc_on, o_led_en;
    logic o_led_derate, o_fault_pin_out, o_fault_pin_oe;
    ////////////////////////////////////////////////////////////////////
    // short retest count keeps the run brief
    lcfs_supervisor #(.NCH(10), .RETEST_CYC(4)) u_lcfs_supervisor (
        .i_clk(i_clk), .i_rst(i_rst), .i_ch_enable(10'h3ff),
        .i_ch_in_reg(i_ch_in_reg), .i_ch_gnd(i_ch_gnd),
        .i_overvoltage_trip(i_overvoltage_trip),
        .i_ov_below_94(i_ov_below_94), .i_in_ocp(i_in_ocp),
        .i_out_uv(i_out_uv), .i_temp_warn(i_temp_warn),
        .i_uv_auto_restart(uv_auto), .i_tw_auto_restart(1'b1),
        .i_fault_clear(i_fault_clear), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
        .o_reg_valid(o_reg_valid), .o_boost_raise_req(o_boost_raise_req),
        .o_ch_active(o_ch_active), .o_gnd_test(o_gnd_test),
        .o_boost_en(o_boost_en), .o_in_disc_on(o_in_disc_on),
        .o_led_en(o_led_en), .o_led_derate(o_led_derate),
        .o_fault_pin_out(o_fault_pin_out), .o_fault_pin_oe(o_fault_pin_oe));
    lcfs_plant u_lcfs_plant (.i_clk(i_clk), .i_boost_en(o_boost_en),
        .i_raise(o_boost_raise_req), .i_gnd_test(o_gnd_test),
        .i_open(open_ch), .i_short(short_ch), .i_surge(surge),
        .o_in_reg(i_ch_in_reg), .o_gnd(i_ch_gnd),
        .o_ovt(i_overvoltage_trip), .o_below(i_ov_below_94));
    ////////////////////////////////////////////////////////////////////
    // one read: strobe for one edge, answer seen the cycle after
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        `CHK(o_reg_valid, 1'b1)
        `CHK(o_reg_rdata, e)
    endtask
    task automatic clr();
        @(posedge i_clk);
        i_fault_clear <= 1'b1;
        @(posedge i_clk);
        i_fault_clear <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        forever #10 i_clk = ~i_clk;
    end
    // watchdog: the tests need about 300 cycles, allow over thirty times that
    initial
    begin
        #200000;
        err_total++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int j = 0; j < 6; j++)
            rd(8'h38 + 8'(j), 8'h00);
        rd(8'h40, 8'h00);
        $display("reset test done");
        // two open channels, one in each status byte
        `WAITC(o_boost_raise_req === 10'h000)
        @(posedge i_clk);
        open_ch <= 10'h208;
        repeat (4) @(posedge i_clk);
        #1;
        `CHK(o_boost_raise_req, 10'h208)
        `WAITC(o_gnd_test === 1'b1)
        `CHK(o_fault_pin_oe, 1'b1)
        `CHK(o_boost_en, 1'b0)
        `WAITC(o_gnd_test === 1'b0)
        `CHK(o_ch_active, 10'h1f7)
        `CHK(o_fault_pin_oe, 1'b0)
        rd(8'h3a, 8'h08);
        rd(8'h3b, 8'h02);
        rd(8'h39, 8'h01);
        $display("open test done");
        // surge while all regulate: boost pauses, nobody is removed
        // a stale trip may still hold the boost, so start from run
        `WAITC(o_boost_en === 1'b1)
        @(posedge i_clk);
        surge <= 1'b1;
        @(posedge i_clk);
        surge <= 1'b0;
        `WAITC(o_boost_en === 1'b0)
        `CHK({o_led_en, o_gnd_test}, 2'h2)
        `WAITC(o_boost_en === 1'b1)
        `CHK(o_ch_active, 10'h1f7)
        rd(8'h38, 8'h08);
        clr();
        rd(8'h39, 8'h00);
        $display("hold test done");
        // input overcurrent stays latched until the host clears it
        @(posedge i_clk);
        i_in_ocp <= 1'b1;
        `WAITC(o_in_disc_on === 1'b0)
        `CHK({o_boost_en, o_led_en, o_fault_pin_oe}, 3'h1)
        @(posedge i_clk);
        i_in_ocp <= 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
        `CHK(o_in_disc_on, 1'b0)
        rd(8'h38, 8'h01);
        clr();
        `WAITC(o_boost_en === 1'b1)
        `CHK(o_in_disc_on, 1'b1)
        $display("overcurrent test done");
        // undervoltage with auto restart, then temperature warning
        @(posedge i_clk);
        i_out_uv <= 1'b1;
        `WAITC(o_boost_en === 1'b0)
        `CHK({o_in_disc_on, o_led_en, o_fault_pin_oe}, 3'h5)
        @(posedge i_clk);
        i_out_uv <= 1'b0;
        `WAITC(o_boost_en === 1'b1)
        `CHK(o_in_disc_on, 1'b1)
        // warning raised while running, so the boost must keep going
        @(posedge i_clk);
        i_temp_warn <= 1'b1;
        `WAITC(o_led_derate === 1'b1)
        `CHK({o_boost_en, o_fault_pin_oe}, 2'h2)
        rd(8'h38, 8'h06);
        // latched undervoltage waits for the host once the pin is low
        @(posedge i_clk);
        i_temp_warn <= 1'b0;
        uv_auto <= 1'b0;
        i_out_uv <= 1'b1;
        `WAITC(o_boost_en === 1'b0)
        @(posedge i_clk);
        i_out_uv <= 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
        `CHK({o_boost_en, o_led_derate}, 2'h0)
        clr();
        `WAITC(o_boost_en === 1'b1)
        `CHK(o_led_en, 1'b1)
        rd(8'h38, 8'h00);
        $display("uv and warning test done");
        // grounded pin: permanent shutdown, shorted channel reported
        @(posedge i_clk);
        i_temp_warn <= 1'b0;
        short_ch <= 10'h020;
        `WAITC(o_gnd_test === 1'b1)
        `WAITC(o_gnd_test === 1'b0)
        repeat (20) @(posedge i_clk);
        #1;
        `CHK({o_boost_en, o_in_disc_on, o_fault_pin_oe}, 3'h1)
        rd(8'h3c, 8'h20);
        rd(8'h3d, 8'h00);
        rd(8'h39, 8'h02);
        @(posedge i_clk);
        short_ch <= 10'h000;
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(8'h3a, 8'h00);
        `CHK(o_in_disc_on, 1'b1)
        $display("ground test done");
        finish_test();
    end
endmodule
